// ---- fir_filter_end.sv ----
// Filter end: sample sink, result source with FIFO, coefficient port
// Behaviour
// - Start marker means channel zero sample
// - Producer marks last channel with end marker
// - Producer reports sink errors on two bits
// - Filter reports source errors on two bits
// - Ready ignored when backpressure disabled
// - Output valid only with valid data
// - Output channel index identifies result channel
// - Lane zero in lowest output bits
// - Output start marker flags channel zero
// - Output end marker flags last channel
// - Write enable stores data at address
// - Read data returned with valid flag
// - Input ready when able; idle without valid
// - Async low reset; own coefficient clock, reset
// - Write data 16 or 32 bits wide
module fir_filter_end
    import fir_pkg::*;
#(
    parameter bit BACKPRESSURE = 1'b1
) (
    // Link to partners
    fir_link_if.filter LNK,
    // Status
    output logic [CHAN_W-1:0] NEXT_CHAN_O,
    output logic [1:0] SNK_ERR_SEEN_O
);
    localparam int ENTRY_W = BUS_W + CHAN_W + 2 + 2;

    logic [CHAN_W-1:0] chan_ff;
    logic [1:0] snk_err_ff;
    logic [BUS_W-1:0] acc_ff;
    logic [COEF_W-1:0] coef_mem [COEF_NUM];
    logic [COEF_W-1:0] coef_rdata_ff;
    logic coef_rvalid_ff;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out_data;

    function automatic logic [DATA_W-1:0] lane_of(input logic [BUS_W-1:0] bus, input int idx);
        lane_of = bus[idx*DATA_W +: DATA_W];
    endfunction

    // Sample taken when producer valid and filter ready
    wire take = LNK.snk_valid && LNK.snk_ready;
    wire [CHAN_W-1:0] cur_chan = LNK.snk_sop ? CHAN_FIRST : chan_ff;
    wire last_chan = (cur_chan == CHAN_LAST);
    // Stream marker checks of the producer's framing
    wire miss_sop = (chan_ff == CHAN_FIRST) && !LNK.snk_sop && take;
    wire miss_eop = last_chan && !LNK.snk_eop && take;
    wire bad_eop = !last_chan && LNK.snk_eop && take;
    wire [1:0] src_err_now = bad_eop ? ERR_OTHER : miss_eop ? ERR_NO_EOP :
        miss_sop ? ERR_NO_SOP : ERR_NONE;
    wire [1:0] carry_err = (LNK.snk_error != ERR_NONE) ? LNK.snk_error : src_err_now;

    // Simple tap: result per lane is sample plus previous sample of the lane
    logic [BUS_W-1:0] result;
    always_comb begin
        result = '0;
        for (int i = 0; i < LANES; i++) begin
            result[i*DATA_W +: DATA_W] = lane_of(LNK.snk_data, i) + lane_of(acc_ff, i);
        end
    end

    wire [ENTRY_W-1:0] entry = {carry_err, cur_chan == CHAN_FIRST, last_chan, cur_chan, result};

    assign LNK.snk_ready = BACKPRESSURE ? fifo_in_ready : 1'b1;

    always_ff @(posedge LNK.clk or negedge LNK.reset_n) begin
        if (!LNK.reset_n) begin
            chan_ff <= CHAN_FIRST;
            acc_ff <= '0;
            snk_err_ff <= ERR_NONE;
        end else if (take) begin
            chan_ff <= last_chan ? CHAN_FIRST : cur_chan + 1'b1;
            acc_ff <= LNK.snk_data;
            snk_err_ff <= LNK.snk_error;
        end
    end

    fir_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_out_fifo (
        .clk_i(LNK.clk),
        .rst_n_i(LNK.reset_n),
        .in_valid_i(take),
        .in_ready_o(fifo_in_ready),
        .in_data_i(entry),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(BACKPRESSURE ? LNK.src_ready : 1'b1),
        .out_data_o(fifo_out_data)
    );

    // Head of FIFO stays put until popped
    assign LNK.src_valid = fifo_out_valid;
    assign LNK.src_data = fifo_out_data[BUS_W-1:0];
    assign LNK.src_channel = fifo_out_data[BUS_W +: CHAN_W];
    assign LNK.src_eop = fifo_out_data[BUS_W+CHAN_W];
    assign LNK.src_sop = fifo_out_data[BUS_W+CHAN_W+1];
    assign LNK.src_error = fifo_out_valid ? fifo_out_data[ENTRY_W-1 -: 2] : ERR_NONE;

    always_ff @(posedge LNK.coef_clk) begin
        if (LNK.coef_we) begin
            coef_mem[LNK.coef_addr] <= LNK.coef_wdata[COEF_W-1:0];
        end
    end

    always_ff @(posedge LNK.coef_clk or posedge LNK.coef_rst) begin
        if (LNK.coef_rst) begin
            coef_rdata_ff <= '0;
            coef_rvalid_ff <= 1'b0;
        end else begin
            coef_rdata_ff <= coef_mem[LNK.coef_addr];
            coef_rvalid_ff <= !LNK.coef_we;
        end
    end

    assign LNK.coef_rdata = coef_rdata_ff;
    assign LNK.coef_rvalid = coef_rvalid_ff;
    assign NEXT_CHAN_O = chan_ff;
    assign SNK_ERR_SEEN_O = snk_err_ff;
endmodule

// ---- fir_pkg.sv ----
// Shared constants for the filter stream and coefficient port
package fir_pkg;
    localparam int DATA_W = 8;
    localparam int LANES = 4;
    localparam int CHANS = 4;
    localparam int CHAN_W = 2;
    localparam int BANK_W = 0;
    localparam int BUS_W = DATA_W * LANES;
    localparam int COEF_W = 16;
    localparam int COEF_BUS_W = (COEF_W <= 16) ? 16 : 32;
    localparam int COEF_NUM = 32;
    localparam int COEF_AW = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_NO_SOP = 2'h1;
    localparam logic [1:0] ERR_NO_EOP = 2'h2;
    localparam logic [1:0] ERR_OTHER = 2'h3;
    localparam logic [CHAN_W-1:0] CHAN_FIRST = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_LAST = 2'h3;
endpackage

// ---- fir_link_if.sv ----
// Interface joining the filter and its partners
interface fir_link_if;
    import fir_pkg::*;
    logic clk;
    logic reset_n;
    logic coef_clk;
    logic coef_rst;
    logic snk_valid;
    logic snk_ready;
    logic [BUS_W-1:0] snk_data;
    logic snk_sop;
    logic snk_eop;
    logic [1:0] snk_error;
    logic src_valid;
    logic src_ready;
    logic [BUS_W-1:0] src_data;
    logic [CHAN_W-1:0] src_channel;
    logic src_sop;
    logic src_eop;
    logic [1:0] src_error;
    logic [COEF_AW-1:0] coef_addr;
    logic coef_we;
    logic [COEF_BUS_W-1:0] coef_wdata;
    logic [COEF_W-1:0] coef_rdata;
    logic coef_rvalid;
    modport filter (input clk, reset_n, coef_clk, coef_rst, snk_valid, snk_data, snk_sop, snk_eop,
        snk_error, src_ready, coef_addr, coef_we, coef_wdata,
        output snk_ready, src_valid, src_data, src_channel, src_sop, src_eop, src_error,
        coef_rdata, coef_rvalid);
    modport partner (input clk, reset_n, coef_clk, coef_rst, snk_ready, src_valid, src_data,
        src_channel, src_sop, src_eop, src_error, coef_rdata, coef_rvalid,
        output snk_valid, snk_data, snk_sop, snk_eop, snk_error, src_ready, coef_addr, coef_we,
        coef_wdata);
endinterface

// ---- fir_fifo.sv ----
// Parameterised valid/ready FIFO
module fir_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count_ff < (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem[rd_ptr_ff];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- fir_partner_end.sv ----
// Partner end: sample producer, result consumer, coefficient master
module fir_partner_end
    import fir_pkg::*;
(
    // Link to filter
    fir_link_if.partner LNK,
    // Sample request
    input wire logic SMP_VALID_I,
    output logic SMP_READY_O,
    input wire logic [BUS_W-1:0] SMP_DATA_I,
    input wire logic [1:0] SMP_ERROR_I,
    // Result delivery
    output logic RES_VALID_O,
    input wire logic RES_READY_I,
    output logic [BUS_W-1:0] RES_DATA_O,
    output logic [CHAN_W-1:0] RES_CHAN_O,
    // Coefficient request
    input wire logic COEF_WE_I,
    input wire logic [COEF_AW-1:0] COEF_ADDR_I,
    input wire logic [COEF_W-1:0] COEF_DATA_I,
    output logic [COEF_W-1:0] COEF_RDATA_O,
    output logic COEF_RVALID_O
);
    logic [CHAN_W-1:0] chan_ff;
    wire sent = SMP_VALID_I && LNK.snk_ready;

    assign LNK.snk_valid = SMP_VALID_I;
    assign SMP_READY_O = LNK.snk_ready;
    assign LNK.snk_data = SMP_DATA_I;
    assign LNK.snk_sop = (chan_ff == CHAN_FIRST);
    assign LNK.snk_eop = (chan_ff == CHAN_LAST);
    assign LNK.snk_error = SMP_ERROR_I;
    assign LNK.src_ready = RES_READY_I;
    assign RES_VALID_O = LNK.src_valid;
    assign RES_DATA_O = LNK.src_data;
    assign RES_CHAN_O = LNK.src_channel;
    assign LNK.coef_we = COEF_WE_I;
    assign LNK.coef_addr = COEF_ADDR_I;
    assign LNK.coef_wdata = COEF_BUS_W'(COEF_DATA_I);
    assign COEF_RDATA_O = LNK.coef_rdata;
    assign COEF_RVALID_O = LNK.coef_rvalid;

    always_ff @(posedge LNK.clk or negedge LNK.reset_n) begin
        if (!LNK.reset_n) begin
            chan_ff <= CHAN_FIRST;
        end else if (sent) begin
            chan_ff <= (chan_ff == CHAN_LAST) ? CHAN_FIRST : chan_ff + 1'b1;
        end
    end
endmodule

// ---- fir_link_monitor.sv ----
// Assertions on the signals of the filter link
module fir_link_monitor
    import fir_pkg::*;
(
    // Clocks and resets
    input wire logic clk,
    input wire logic reset_n,
    input wire logic coef_clk,
    input wire logic coef_rst,
    // Streams
    input wire logic snk_valid,
    input wire logic snk_ready,
    input wire logic snk_sop,
    input wire logic [1:0] snk_error,
    input wire logic src_valid,
    input wire logic src_ready,
    input wire logic [BUS_W-1:0] src_data,
    input wire logic [CHAN_W-1:0] src_channel,
    input wire logic src_sop,
    input wire logic src_eop,
    input wire logic [1:0] src_error,
    // Coefficient port
    input wire logic [COEF_AW-1:0] coef_addr,
    input wire logic coef_we,
    input wire logic [COEF_BUS_W-1:0] coef_wdata,
    input wire logic [COEF_W-1:0] coef_rdata,
    input wire logic coef_rvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Sample taken while the buffer is empty
    wire take = snk_valid && snk_ready && !src_valid;

    a_sop_chan0: assert property (src_valid |-> src_sop == (src_channel == CHAN_FIRST))
        else $error("start marker off channel 0");
    a_eop_last: assert property (src_valid |-> src_eop == (src_channel == CHAN_LAST))
        else $error("end marker off last channel");
    a_stall_hold: assert property (src_valid && !src_ready |=>
        src_valid && $stable({src_data, src_channel, src_sop, src_eop, src_error}))
        else $error("stalled output changed");
    a_idle_ready: assert property (!src_valid |-> snk_ready)
        else $error("input not ready while empty");
    a_take_out: assert property (take |=> src_valid)
        else $error("no result after sample");
    a_take_chan: assert property (take && snk_sop |=> src_sop && src_channel == CHAN_FIRST)
        else $error("start sample not channel 0");
    a_err_pass: assert property (take && snk_error != ERR_NONE |=> src_error == $past(snk_error))
        else $error("error code not passed");
    a_reset_empty: assert property ($rose(reset_n) |-> !src_valid)
        else $error("output valid after reset");
    a_we_refuse: assert property (@(posedge coef_clk) disable iff (coef_rst) coef_we |=> !coef_rvalid)
        else $error("read valid after write");
    a_coef_back: assert property (@(posedge coef_clk) disable iff (coef_rst)
        coef_we ##1 (!coef_we && $stable(coef_addr)) |=>
        coef_rvalid && coef_rdata == $past(coef_wdata[COEF_W-1:0], 2))
        else $error("coefficient read back wrong");

    c_take_sop: cover property (take && snk_sop);
    c_stall: cover property (src_valid && !src_ready ##1 src_valid && src_ready);
    c_coef: cover property (@(posedge coef_clk) coef_we ##1 !coef_we);
endmodule

// ---- fir_stream_and_coef_port_test.sv ----
// Self-checking bench for the filter and partner ends
module fir_stream_and_coef_port_test
    import fir_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    int error_cnt = 0;
    int checks = 0;
    int rmode = 2;
    logic smp_valid = 1'b0;
    logic res_ready = 1'b0;
    logic coef_we = 1'b0;
    logic [BUS_W-1:0] smp_data = '0;
    logic [BUS_W-1:0] prev = '0;
    logic [1:0] smp_err = 2'h0;
    logic [COEF_AW-1:0] coef_addr = '0;
    logic [COEF_W-1:0] coef_data = '0;
    logic [COEF_W-1:0] cmem [COEF_NUM];
    logic [CHAN_W-1:0] rchan = '0;
    logic [CHAN_W-1:0] schan = '0;
    logic [BUS_W-1:0] exp_q [$];
    wire smp_ready;
    wire res_valid;
    wire coef_rvalid;
    wire [BUS_W-1:0] res_data;
    wire [CHAN_W-1:0] res_chan;
    wire [COEF_W-1:0] coef_rdata;
    wire [CHAN_W-1:0] next_chan;
    wire [1:0] err_seen;
    wire nb_ready;
    wire nb_valid;

    fir_link_if lnk();
    assign lnk.clk = clk;
    assign lnk.coef_clk = clk;
    assign lnk.reset_n = rst_n;
    assign lnk.coef_rst = !rst_n;

    fir_filter_end #(.BACKPRESSURE(1'b1)) i_fir_filter_end (.LNK(lnk), .NEXT_CHAN_O(next_chan),
        .SNK_ERR_SEEN_O(err_seen));
    fir_partner_end i_fir_partner_end (.LNK(lnk), .SMP_VALID_I(smp_valid), .SMP_READY_O(smp_ready),
        .SMP_DATA_I(smp_data), .SMP_ERROR_I(smp_err), .RES_VALID_O(res_valid), .RES_READY_I(res_ready),
        .RES_DATA_O(res_data), .RES_CHAN_O(res_chan), .COEF_WE_I(coef_we), .COEF_ADDR_I(coef_addr),
        .COEF_DATA_I(coef_data), .COEF_RDATA_O(coef_rdata), .COEF_RVALID_O(coef_rvalid));
    fir_link_monitor i_fir_link_monitor (.clk(lnk.clk), .reset_n(lnk.reset_n), .coef_clk(lnk.coef_clk),
        .coef_rst(lnk.coef_rst), .snk_valid(lnk.snk_valid), .snk_ready(lnk.snk_ready),
        .snk_sop(lnk.snk_sop), .snk_error(lnk.snk_error), .src_valid(lnk.src_valid),
        .src_ready(lnk.src_ready), .src_data(lnk.src_data), .src_channel(lnk.src_channel),
        .src_sop(lnk.src_sop), .src_eop(lnk.src_eop), .src_error(lnk.src_error),
        .coef_addr(lnk.coef_addr), .coef_we(lnk.coef_we), .coef_wdata(lnk.coef_wdata),
        .coef_rdata(lnk.coef_rdata), .coef_rvalid(lnk.coef_rvalid));

    // Second pair without backpressure, fed the same samples
    fir_link_if lnk_nb();
    assign lnk_nb.clk = clk;
    assign lnk_nb.coef_clk = clk;
    assign lnk_nb.reset_n = rst_n;
    assign lnk_nb.coef_rst = !rst_n;

    fir_filter_end #(.BACKPRESSURE(1'b0)) i_fir_filter_end_nb (.LNK(lnk_nb), .NEXT_CHAN_O(), .SNK_ERR_SEEN_O());
    fir_partner_end i_fir_partner_end_nb (.LNK(lnk_nb), .SMP_VALID_I(smp_valid), .SMP_READY_O(nb_ready),
        .SMP_DATA_I(smp_data), .SMP_ERROR_I(smp_err), .RES_VALID_O(nb_valid), .RES_READY_I(res_ready),
        .RES_DATA_O(), .RES_CHAN_O(), .COEF_WE_I(1'b0), .COEF_ADDR_I(coef_addr), .COEF_DATA_I(coef_data),
        .COEF_RDATA_O(), .COEF_RVALID_O());

    // Each lane plus the same lane of the previous sample
    function automatic logic [BUS_W-1:0] lane_sum(logic [BUS_W-1:0] s, logic [BUS_W-1:0] p);
        for (int i = 0; i < LANES; i++) begin
            lane_sum[DATA_W*i+:DATA_W] = s[DATA_W*i+:DATA_W] + p[DATA_W*i+:DATA_W];
        end
    endfunction

    task automatic chk(string name, logic [BUS_W-1:0] e, logic [BUS_W-1:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic send(int n);
        repeat (n) begin
            @(negedge clk);
            smp_valid = 1'b1;
            smp_data = $urandom;
            smp_err = $urandom;
            while (smp_ready !== 1'b1) @(negedge clk);
            exp_q.push_back(lane_sum(smp_data, prev));
            schan = (schan == CHAN_LAST) ? CHAN_FIRST : schan + 1'b1;
            prev = smp_data;
        end
        @(negedge clk);
        smp_valid = 1'b0;
        chk("next channel", schan, next_chan);
        chk("sink error seen", smp_err, err_seen);
    endtask

    task automatic drain();
        rmode = 2;
        repeat (200) if (exp_q.size() != 0) @(negedge clk);
        chk("pending results", 0, exp_q.size());
    endtask

    // Read cycle two edges after the address, none while writing
    task automatic coef_rw(logic [COEF_AW-1:0] a, logic [COEF_W-1:0] d, logic we);
        @(negedge clk);
        coef_we = we;
        coef_addr = a;
        coef_data = d;
        @(negedge clk);
        coef_we = 1'b0;
        if (we) chk("coef valid in write", 0, coef_rvalid);
        @(negedge clk);
        chk("coef valid", 1, coef_rvalid);
        chk("coef data", d, coef_rdata);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Consumer: random, stalled or always ready
    always @(negedge clk) begin
        res_ready = (rmode == 2) || (rmode == 1 && $urandom_range(1) == 1);
        if (res_valid === 1'b1 && res_ready) begin
            chk("result data", exp_q.size() ? exp_q.pop_front() : 'x, res_data);
            chk("result channel", rchan, res_chan);
            rchan++;
        end
    end

    initial begin
        forever #2 clk = ~clk;
    end

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        void'($urandom(87));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rmode = 1;
        send(62);
        drain();
        $display("stream test done");
        rmode = 0;
        send(FIFO_DEPTH);
        chk("ready when full", 0, smp_ready);
        chk("ready without backpressure", 1, nb_ready);
        @(negedge clk);
        chk("output without backpressure", 0, nb_valid);
        drain();
        $display("fill test done");
        foreach (cmem[a]) begin
            cmem[a] = $urandom;
            coef_rw(a, cmem[a], 1'b1);
        end
        foreach (cmem[a]) coef_rw(a, cmem[a], 1'b0);
        $display("coefficient test done");
        report_and_stop();
    end
endmodule
